// file: design/adc_conversion_sequencer.sv
/*
 * conversion sequencer of the sigma-delta converter: rate selection,
 * input stepping, interval timing and the active-low ready pin, with an
 * apb register slave and a level interrupt.
 * assumes seq_defs.svh and seq_pkg are compiled first and that all inputs
 * are synchronous to pclk.
 */
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/10ps
`include "seq_defs.svh"

// What this block does
// - five rates: 10, 20, 1.2k, 4.8k, 9.6k SPS
// - mains rejection only at 10 or 20 SPS
// - each channel has own rate in setup
// - one shared rate for all diagnostic inputs
// - timing runs off internal clock, not spi
// - 100 us power-up when converter was down
// - rate-dependent pipeline delay before first conversion
// - conversion time depends on selected rate
// - switch interval between inputs when several enabled
// - continuous repeats: switch plus conversion per input, conversion only with one input enabled
// - ready pin low at end of sequence
// - writing one to ready flag releases pin
// - continuous mode: pin releases after 24 us
// - control register write releases ready pin
// - diagnostic rate only 9.6k, 4.8k, 20 SPS
module adc_conversion_sequencer #(
    parameter int unsigned PIPE_10_CYC = `CYC_UP(`T_PIPE_10_NS),
    parameter int unsigned CONV_1K2_CYC = `CYC_UP(`T_CONV_1K2_NS),
    parameter int unsigned CONV_20_CYC = `CYC_UP(`T_CONV_20_NS),
    parameter int unsigned CONV_10_CYC = `CYC_UP(`T_CONV_10_NS),
    parameter int unsigned SW_10_CYC = `CYC_UP(`T_SW_10_NS)
)(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter status
    output logic adc_rdy_n,
    output logic irq,
    output logic mains_reject,
    output logic converting,
    output logic [2:0] cur_input
);

    localparam logic [19:0] PWRUP_CYC = 20'(`CYC_UP(`T_PWRUP_NS));
    localparam logic [19:0] PIPE_9K6_CYC = 20'(`CYC_UP(`T_PIPE_9K6_NS));
    localparam logic [19:0] PIPE_4K8_CYC = 20'(`CYC_UP(`T_PIPE_4K8_NS));
    localparam logic [19:0] PIPE_20_CYC = 20'(`CYC_UP(`T_PIPE_20_NS));
    localparam logic [19:0] CONV_9K6_CYC = 20'(`CYC_UP(`T_CONV_9K6_NS));
    localparam logic [19:0] CONV_4K8_CYC = 20'(`CYC_UP(`T_CONV_4K8_NS));
    localparam logic [19:0] SW_FAST_CYC = 20'(`CYC_UP(`T_SW_FAST_NS));
    localparam logic [19:0] SW_20_CYC = 20'(`CYC_UP(`T_SW_20_NS));
    localparam logic [7:0] RDY_CYC = 8'(`CYC_UP(`T_RDY_NS));

    seq_pkg::seq_state_s q_r;
    seq_pkg::seq_state_s q_nxt;

    // counter load for a timed phase at a rate: its length in cycles minus one
    function automatic logic [19:0] dur(seq_pkg::seq_e ph,
                                        seq_pkg::rate_e r);
        logic [19:0] d;
        d = CONV_9K6_CYC;
        case (ph)
            seq_pkg::ST_PIPE:
            begin
                case (r)
                    seq_pkg::RATE_9K6: d = PIPE_9K6_CYC;
                    seq_pkg::RATE_20: d = PIPE_20_CYC;
                    seq_pkg::RATE_10: d = 20'(PIPE_10_CYC);
                    default: d = PIPE_4K8_CYC;
                endcase
            end
            seq_pkg::ST_SWITCH:
            begin
                case (r)
                    seq_pkg::RATE_20: d = SW_20_CYC;
                    seq_pkg::RATE_10: d = 20'(SW_10_CYC);
                    default: d = SW_FAST_CYC;
                endcase
            end
            default:
            begin
                case (r)
                    seq_pkg::RATE_9K6: d = CONV_9K6_CYC;
                    seq_pkg::RATE_4K8: d = CONV_4K8_CYC;
                    seq_pkg::RATE_1K2: d = 20'(CONV_1K2_CYC);
                    seq_pkg::RATE_20: d = 20'(CONV_20_CYC);
                    default: d = 20'(CONV_10_CYC);
                endcase
            end
        endcase
        return d - 20'd1;
    endfunction

    // inputs 0..1 are channels, 2..5 diagnostics sharing one rate
    function automatic seq_pkg::rate_e rate_of(seq_pkg::seq_state_s s,
                                               logic [2:0] i);
        seq_pkg::rate_e r;
        r = s.diag_rate;
        if (i < 3'd2)
            r = s.ch_rate[i[0]];
        return r;
    endfunction

    // lowest enabled input at or above a start index; msb says found
    function automatic logic [3:0] next_in(logic [5:0] m, logic [2:0] from);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 5; i >= 0; i--)
        begin
            if (m[i] && 3'(i) >= from)
                res = {1'b1, 3'(i)};
        end
        return res;
    endfunction

    function automatic logic is_mains(seq_pkg::rate_e r);
        return r == seq_pkg::RATE_10 || r == seq_pkg::RATE_20;
    endfunction

    function automatic logic [31:0] rdata(logic [7:0] a,
                                          seq_pkg::seq_state_s s);
        logic [31:0] d;
        d = 32'h0;
        case (a)
            `OFS_CTRL:
                d = 32'({s.diag_rate == seq_pkg::RATE_20 ? 2'h2 :
                         s.diag_rate == seq_pkg::RATE_4K8 ? 2'h1 : 2'h0,
                         s.mode, s.en});
            `OFS_CH0_SETUP: d = 32'(s.ch_rate[0]);
            `OFS_CH1_SETUP: d = 32'(s.ch_rate[1]);
            `OFS_LIVE:
            begin
                d[`LIVE_DRDY_BIT] = s.drdy;
                d[`LIVE_BUSY_BIT] = s.busy;
                d[`LIVE_MAINS_BIT] = s.mains;
                d[`LIVE_IDX_LSB +: 3] = s.idx;
            end
            `OFS_PSAVE: d = 32'(s.psave);
            `OFS_IRQ_STAT: d = 32'(s.irq_stat);
            `OFS_IRQ_MASK: d = 32'(s.irq_mask);
            default: d = 32'h0;
        endcase
        return d;
    endfunction

    function automatic logic mapped(logic [7:0] a);
        return a == `OFS_CTRL || a == `OFS_CH0_SETUP ||
               a == `OFS_CH1_SETUP || a == `OFS_LIVE ||
               a == `OFS_PSAVE || a == `OFS_IRQ_STAT ||
               a == `OFS_IRQ_MASK;
    endfunction

    always_comb
    begin
        logic wr;
        logic seq_done;
        logic conv_done;
        logic multi;
        logic [3:0] nx;
        logic [3:0] first;
        logic [1:0] drate;
        q_nxt = q_r;
        wr = psel & penable & pwrite & q_r.pready;
        seq_done = 1'b0;
        conv_done = 1'b0;
        multi = (q_r.en & (q_r.en - 6'd1)) != 6'h0;
        nx = 4'h0;
        first = next_in(q_r.en, 3'd0);
        drate = pwdata[`CTRL_DRATE_LSB +: 2];

        // apb: answer prepared in setup, zero wait states
        q_nxt.pready = psel & ~penable;
        q_nxt.pslverr = psel & ~penable & ~mapped(paddr);
        if (psel & ~penable)
            q_nxt.prdata = rdata(paddr, q_r);

        // interval timer on pclk, not on the serial clock
        if (q_r.cnt != 20'h0)
            q_nxt.cnt = q_r.cnt - 20'd1;
        else
        begin
            case (q_r.st)
                seq_pkg::ST_IDLE:
                    q_nxt.st = seq_pkg::ST_IDLE;
                seq_pkg::ST_POWERUP:
                begin
                    q_nxt.adc_on = 1'b1;
                    q_nxt.st = seq_pkg::ST_PIPE;
                    q_nxt.cnt = dur(seq_pkg::ST_PIPE,
                                    rate_of(q_r, q_r.idx));
                end
                seq_pkg::ST_PIPE, seq_pkg::ST_SWITCH:
                begin
                    q_nxt.st = seq_pkg::ST_CONVERT;
                    q_nxt.cnt = dur(seq_pkg::ST_CONVERT,
                                    rate_of(q_r, q_r.idx));
                end
                seq_pkg::ST_CONVERT:
                begin
                    conv_done = 1'b1;
                    nx = next_in(q_r.en, q_r.idx + 3'd1);
                    if (nx[3])
                    begin
                        q_nxt.idx = nx[2:0];
                        q_nxt.st = seq_pkg::ST_SWITCH;
                        q_nxt.cnt = dur(seq_pkg::ST_SWITCH,
                                        rate_of(q_r, nx[2:0]));
                    end
                    else
                    begin
                        seq_done = 1'b1;
                        q_nxt.idx = first[2:0];
                        if (q_r.mode == seq_pkg::MODE_CONT)
                        begin
                            // repeats skip power-up and pipeline
                            q_nxt.st = multi ? seq_pkg::ST_SWITCH :
                                seq_pkg::ST_CONVERT;
                            q_nxt.cnt = dur(q_nxt.st,
                                            rate_of(q_r, first[2:0]));
                        end
                        else
                        begin
                            q_nxt.st = seq_pkg::ST_IDLE;
                            q_nxt.mode = seq_pkg::MODE_STOP;
                        end
                    end
                end
                default:
                    q_nxt.st = seq_pkg::ST_IDLE;
            endcase
        end

        // auto release only in continuous mode
        if (!q_r.rdy_n && q_r.mode == seq_pkg::MODE_CONT)
        begin
            if (q_r.rdy_cnt >= RDY_CYC - 8'd1)
                q_nxt.rdy_n = 1'b1;
            else
                q_nxt.rdy_cnt = q_r.rdy_cnt + 8'd1;
        end

        if (wr)
        begin
            case (paddr)
                `OFS_CTRL:
                begin
                    q_nxt.rdy_n = 1'b1;
                    q_nxt.en = pwdata[`CTRL_EN_LSB +: `CTRL_EN_W];
                    q_nxt.mode = seq_pkg::mode_e'(pwdata[`CTRL_MODE_LSB +: 2]);
                    // unsupported diagnostic codes keep the old rate
                    if (drate == 2'h0)
                        q_nxt.diag_rate = seq_pkg::RATE_9K6;
                    else if (drate == 2'h1)
                        q_nxt.diag_rate = seq_pkg::RATE_4K8;
                    else if (drate == 2'h2)
                        q_nxt.diag_rate = seq_pkg::RATE_20;
                    first = next_in(q_nxt.en, 3'd0);
                    q_nxt.idx = first[2:0];
                    if (q_nxt.mode == seq_pkg::MODE_SINGLE ||
                        q_nxt.mode == seq_pkg::MODE_CONT)
                    begin
                        if (!first[3])
                        begin
                            q_nxt.st = seq_pkg::ST_IDLE;
                            q_nxt.cnt = 20'h0;
                        end
                        else if (!q_r.adc_on)
                        begin
                            q_nxt.st = seq_pkg::ST_POWERUP;
                            q_nxt.cnt = PWRUP_CYC - 20'd1;
                        end
                        else
                        begin
                            q_nxt.st = seq_pkg::ST_PIPE;
                            q_nxt.cnt = dur(seq_pkg::ST_PIPE,
                                            rate_of(q_nxt, first[2:0]));
                        end
                    end
                    else
                    begin
                        q_nxt.mode = seq_pkg::MODE_STOP;
                        q_nxt.st = seq_pkg::ST_IDLE;
                        q_nxt.cnt = 20'h0;
                    end
                end
                `OFS_CH0_SETUP, `OFS_CH1_SETUP:
                begin
                    // codes above the five rates are ignored
                    if (pwdata[2:0] <= 3'(seq_pkg::RATE_9K6))
                        q_nxt.ch_rate[paddr[3]] =
                            seq_pkg::rate_e'(pwdata[2:0]);
                end
                `OFS_LIVE:
                begin
                    if (pwdata[`LIVE_DRDY_BIT])
                    begin
                        q_nxt.drdy = 1'b0;
                        q_nxt.rdy_n = 1'b1;
                    end
                end
                `OFS_PSAVE:
                begin
                    // no interlock against writes mid-sequence
                    q_nxt.psave = pwdata[`PSAVE_W-1:0];
                    if (pwdata[`PSAVE_W-1:0] != 5'h0)
                        q_nxt.adc_on = 1'b0;
                end
                `OFS_IRQ_STAT:
                    q_nxt.irq_stat = q_r.irq_stat & ~pwdata[1:0];
                `OFS_IRQ_MASK:
                    q_nxt.irq_mask = pwdata[1:0];
                default:
                    q_nxt.irq_mask = q_nxt.irq_mask;
            endcase
        end

        // hardware events win over any clear in the same cycle
        if (seq_done)
        begin
            q_nxt.rdy_n = 1'b0;
            q_nxt.rdy_cnt = 8'h0;
            q_nxt.drdy = 1'b1;
            q_nxt.irq_stat[0] = 1'b1;
        end
        if (conv_done)
            q_nxt.irq_stat[1] = 1'b1;

        q_nxt.irq = |(q_nxt.irq_stat & q_nxt.irq_mask);
        q_nxt.busy = q_nxt.st != seq_pkg::ST_IDLE;
        q_nxt.mains = q_nxt.busy &&
            is_mains(rate_of(q_nxt, q_nxt.idx));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q_r <= '{st: seq_pkg::ST_IDLE, cnt: 20'h0, idx: 3'h0,
                     en: 6'h0, mode: seq_pkg::MODE_STOP,
                     ch_rate: {seq_pkg::RATE_9K6, seq_pkg::RATE_9K6},
                     diag_rate: seq_pkg::RATE_9K6, psave: `PSAVE_RST,
                     adc_on: 1'b0, rdy_n: 1'b1, rdy_cnt: 8'h0,
                     drdy: 1'b0, irq_stat: 2'h0, irq_mask: 2'h0,
                     irq: 1'b0, mains: 1'b0, busy: 1'b0,
                     prdata: 32'h0, pready: 1'b0, pslverr: 1'b0};
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    assign prdata = q_r.prdata;
    assign pready = q_r.pready;
    assign pslverr = q_r.pslverr;
    assign adc_rdy_n = q_r.rdy_n;
    assign irq = q_r.irq;
    assign mains_reject = q_r.mains;
    assign converting = q_r.busy;
    assign cur_input = q_r.idx;

endmodule

// file: design/seq_defs.svh
/*
 * register offsets, field positions, reset values and timing figures
 * of the conversion sequencer.
 * assumes a 10 MHz pclk; times are kept in ns and turned into cycles here.
 */
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_CH0_SETUP 8'h04
`define OFS_CH1_SETUP 8'h08
`define OFS_LIVE 8'h0c
`define OFS_PSAVE 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_MASK 8'h18

// conversion_control fields
`define CTRL_EN_LSB 0
`define CTRL_EN_W 6
`define CTRL_MODE_LSB 6
`define CTRL_DRATE_LSB 8

// live_state_word fields
`define LIVE_DRDY_BIT 0
`define LIVE_BUSY_BIT 1
`define LIVE_MAINS_BIT 2
`define LIVE_IDX_LSB 4

// power_saving_setup width
`define PSAVE_W 5

// reset values
`define CTRL_RST 10'h000
`define CH_RATE_RST 3'h4
`define PSAVE_RST 5'h00

// clock period and documented times, ns
`define PCLK_NS 100
`define T_PWRUP_NS 100000
`define T_PIPE_9K6_NS 55000
`define T_PIPE_4K8_NS 81000
`define T_PIPE_20_NS 87000
`define T_PIPE_10_NS 5000000
`define T_CONV_9K6_NS 104170
`define T_CONV_4K8_NS 208330
`define T_CONV_1K2_NS 833330
`define T_CONV_20_NS 50000000
`define T_CONV_10_NS 100000000
`define T_SW_FAST_NS 24400
`define T_SW_20_NS 33600
`define T_SW_10_NS 5024000
`define T_RDY_NS 24000

// least times: round up to whole cycles
`define CYC_UP(t) (((t) + `PCLK_NS - 1) / `PCLK_NS)

`endif

// file: design/seq_pkg.sv
/*
 * types of the conversion sequencer: rate and mode encodings, sequencer
 * states and the packed state record.
 * assumes seq_defs.svh is compiled alongside.
 */
package seq_pkg;

    typedef enum logic [2:0] {
        RATE_10,
        RATE_20,
        RATE_1K2,
        RATE_4K8,
        RATE_9K6
    } rate_e;

    typedef enum logic [1:0] {
        MODE_STOP,
        MODE_SINGLE,
        MODE_CONT,
        MODE_RSVD
    } mode_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_POWERUP,
        ST_PIPE,
        ST_SWITCH,
        ST_CONVERT
    } seq_e;

    typedef struct packed {
        seq_e st;
        logic [19:0] cnt;
        logic [2:0] idx;
        logic [5:0] en;
        mode_e mode;
        rate_e [1:0] ch_rate;
        rate_e diag_rate;
        logic [4:0] psave;
        logic adc_on;
        logic rdy_n;
        logic [7:0] rdy_cnt;
        logic drdy;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic irq;
        logic mains;
        logic busy;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } seq_state_s;

endpackage

// file: verif/adc_conversion_sequencer_bench.sv
/* self-checking bench of the conversion sequencer.
   assumes the host model and the bound checker; long counts set to 40. */
`timescale 1ns/10ps
`include "seq_defs.svh"
module adc_conversion_sequencer_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic adc_rdy_n, irq, mains_reject, converting;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0] cur_input;
    logic e;
    logic [2:0] ord[$];
    int n_errors = 0, num_checks = 0, bad, cyc = 0, n, n2;
    adc_conversion_sequencer #(.PIPE_10_CYC(40),
        .CONV_20_CYC(40), .CONV_10_CYC(40), .SW_10_CYC(40))
        i_adc_conversion_sequencer (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_rdy_n(adc_rdy_n), .irq(irq),
        .mains_reject(mains_reject), .converting(converting),
        .cur_input(cur_input));
    host_apb_model i_host_apb_model (.pclk(pclk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .converting(converting));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic x;
        i_host_apb_model.xfer(1'b1, a, d, r, x);
    endtask
    task automatic rd(input logic [7:0] a);
        i_host_apb_model.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // counts are judged within two cycles: edge phase is a design choice
    task automatic chk_near(input int g, input int x);
        chk((g >= x - 2 && g <= x + 2) ? x : g, x);
    endtask
    task automatic wait_low(input logic m);
        logic [2:0] last;
        n = 0;
        bad = 0;
        last = 3'h7;
        // look only after an edge: at the write edge the pin still
        // shows the low level left by the previous sequence
        do
        begin
            @(posedge pclk);
            n++;
            if (converting === 1'b1 && mains_reject !== m)
                bad++;
            if (converting === 1'b1 && cur_input !== last)
            begin
                last = cur_input;
                ord.push_back(cur_input);
            end
        end
        while (adc_rdy_n !== 1'b0 && n < 9000);
    endtask
    task automatic t_regs();
        rd(`OFS_CH0_SETUP);
        chk(q, 32'h4);
        for (int r = 0; r < 5; r++)
        begin
            wr(`OFS_CH0_SETUP, r);
            rd(`OFS_CH0_SETUP);
            chk(q, r);
        end
        wr(`OFS_CH1_SETUP, 32'h5);
        rd(`OFS_CH1_SETUP);
        chk(q, 32'h4);
        wr(`OFS_CTRL, 32'h1c1);
        @(posedge pclk);
        chk({31'h0, converting}, 32'h0);
        rd(`OFS_CTRL);
        chk(q, 32'h101);
        wr(`OFS_CTRL, 32'h300);
        rd(`OFS_CTRL);
        chk(q, 32'h100);
        rd(8'h40);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        $display("register test done");
    endtask
    task automatic t_single();
        wr(`OFS_CTRL, 32'h41);
        wait_low(1'b0);
        chk_near(n, 1000 + 550 + 1042 + 1);
        chk(bad, 0);
        chk({31'h0, converting}, 32'h0);
        rd(`OFS_CTRL);
        chk(32'(q[7:6]), 32'h0);
        rd(`OFS_LIVE);
        chk(q, 32'h1);
        rd(`OFS_IRQ_STAT);
        chk(q, 32'h3);
        chk({31'h0, irq}, 32'h0);
        wr(`OFS_IRQ_MASK, 32'h1);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(`OFS_IRQ_STAT, 32'h1);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        i_host_apb_model.clr_rdy();
        @(posedge pclk);
        chk({31'h0, adc_rdy_n}, 32'h1);
        rd(`OFS_LIVE);
        chk(q, 32'h0);
        i_host_apb_model.psave_wr(32'h1);
        wr(`OFS_CTRL, 32'h41);
        wait_low(1'b0);
        chk_near(n, 1000 + 550 + 1042 + 1);
        wr(`OFS_CTRL, 32'h41);
        wait_low(1'b0);
        chk_near(n, 550 + 1042 + 1);
        $display("single test done");
    endtask
    task automatic t_multi();
        wr(`OFS_CH0_SETUP, 32'h0);
        wr(`OFS_CH1_SETUP, 32'h1);
        ord.delete();
        wr(`OFS_CTRL, 32'h24b);
        wait_low(1'b1);
        chk_near(n, 40 + 40 + 336 + 40 + 336 + 40 + 1);
        chk(bad, 0);
        chk(32'(ord.size()), 32'h3);
        chk(32'(ord[0]), 32'h0);
        chk(32'(ord[1]), 32'h1);
        chk(32'(ord[2]), 32'h3);
        rd(`OFS_CTRL);
        chk(32'(q[9:8]), 32'h2);
        $display("multi input test done");
    endtask
    task automatic t_cont();
        wr(`OFS_CH0_SETUP, 32'h4);
        wr(`OFS_CTRL, 32'h81);
        wait_low(1'b0);
        chk_near(n, 550 + 1042 + 1);
        n2 = 0;
        while (adc_rdy_n !== 1'b1 && n2 < 9000)
        begin
            @(posedge pclk);
            n2++;
        end
        chk_near(n2, 240);
        wait_low(1'b0);
        chk_near(n + n2, 1042);
        wr(`OFS_CTRL, 32'h0);
        @(posedge pclk);
        chk({31'h0, adc_rdy_n}, 32'h1);
        chk({31'h0, converting}, 32'h0);
        $display("continuous test done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_errors++;
            test_done();
        end
    end
    initial
    begin
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_single();
        t_multi();
        t_cont();
        test_done();
    end
endmodule

// file: verif/host_apb_model.sv
/* host model: apb master that starts sequences and releases ready.
   assumes pclk is the sequencer clock. */
`timescale 1ns/10ps
`include "seq_defs.svh"
module host_apb_model (
    // clock
    input wire logic pclk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // sequencer status
    input wire logic converting
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show garbage, not the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    task automatic clr_rdy();
        logic [31:0] q;
        logic e;
        xfer(1'b1, `OFS_LIVE, 32'h1, q, e);
    endtask
    task automatic psave_wr(input logic [31:0] d);
        logic [31:0] q;
        logic e;
        while (converting !== 1'b0) @(posedge pclk);
        xfer(1'b1, `OFS_PSAVE, d, q, e);
    endtask
endmodule

// file: verif/seq_props.sv
/* port checker of the conversion sequencer.
   assumes it is bound into adc_conversion_sequencer. */
`timescale 1ns/10ps
`include "seq_defs.svh"
module seq_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // status
    input wire logic adc_rdy_n,
    input wire logic irq,
    input wire logic mains_reject,
    input wire logic converting,
    input wire logic [2:0] cur_input
);
    wire logic acc = psel && penable && pready && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_pulse_a: assert property (psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_unmapped_a: assert property
        (psel && !penable && paddr > `OFS_IRQ_MASK |=> pslverr)
        else $error("unmapped access without error");
    start_hold_a:
        assert property ($rose(converting) |-> converting [*8])
        else $error("sequence ended too early");
    rdy_at_end_a:
        assert property ($fell(adc_rdy_n) |-> $past(converting))
        else $error("ready low without a sequence");
    ctrl_release_a:
        assert property (acc && paddr == `OFS_CTRL |=> adc_rdy_n)
        else $error("ready kept low after control write");
    flag_release_a:
        assert property
        (acc && paddr == `OFS_LIVE && pwdata[0] |=> adc_rdy_n)
        else $error("ready kept low after flag write");
    mains_busy_a:
        assert property (mains_reject |-> converting)
        else $error("mains rejection while idle");
    single_end_a:
        assert property ($fell(converting) |->
            !adc_rdy_n || $past(acc && paddr == `OFS_CTRL))
        else $error("sequence stopped without ready");
    input_range_a:
        assert property (converting |-> cur_input <= 3'h5)
        else $error("input index out of range");
    cover property ($fell(adc_rdy_n));
    cover property (pslverr);
    cover property ($rose(irq));
endmodule
bind adc_conversion_sequencer seq_props i_seq_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .adc_rdy_n(adc_rdy_n), .irq(irq), .mains_reject(mains_reject),
    .converting(converting), .cur_input(cur_input));
